//--- hdl/sms_spi_mode_supply_ctrl.sv
// SPI register bank with mode, supply and hardware control
`timescale 1ns/1ps
`default_nettype none
module sms_spi_mode_supply_ctrl (
	input  wire logic        clk_in,
	input  wire logic        sys_rst_in,
	input  wire logic        spi_clk_in,
	input  wire logic        spi_cs_n_in,
	input  wire logic        spi_mosi_in,
	output logic             spi_miso_out,
	output logic             spi_miso_oe_out,
	input  wire logic        restart_in,
	input  wire logic        overtemp_in,
	input  wire logic        failure_flag_in,
	output logic [1:0]       mode_out,
	output logic [1:0]       second_supply_enable_out,
	output logic             main_supply_overvoltage_reaction_out,
	output logic [1:0]       main_supply_reset_threshold_out,
	output logic             wd_first_failure_out,
	output logic             reset_output_pin_n_out,
	output logic             failure_output_pins_out
);
	import sms_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Link domain: shifter on the host's clock
	logic [15:0] lk_shift_r;
	logic [4:0]  lk_cnt_r;
	logic [7:0]  lk_tx_r;
	logic        lk_tog_r;
	logic [15:0] lk_frame_r;
	// Chip select clears the count; clock may stop between frames
	always_ff @(posedge spi_clk_in or posedge spi_cs_n_in) begin
		if (spi_cs_n_in) begin
			lk_cnt_r   <= 5'h00;
			lk_shift_r <= 16'h0000;
		end else begin
			lk_shift_r <= {spi_mosi_in, lk_shift_r[15:1]};
			if (lk_cnt_r != 5'h1f)
				lk_cnt_r <= lk_cnt_r + 5'h01;
		end
	end

	// Frame sent LSB first: bits 0..6 address, bit 7 access, 8..15 data [R01] [R02]
	logic [6:0] lk_addr;
	// After eight bits the address sits at 14:8 and the access bit at 15
	assign lk_addr = lk_shift_r[14:8];

	// Transmit byte picked after the address byte; holds the old value [R16]
	always_ff @(negedge spi_clk_in or posedge spi_cs_n_in) begin
		if (spi_cs_n_in)
			lk_tx_r <= 8'h00;
		else if (lk_cnt_r == 5'h08)
			lk_tx_r <= rd_mux(lk_addr);
		else
			lk_tx_r <= {1'b0, lk_tx_r[7:1]};
	end

	assign spi_miso_out    = lk_tx_r[0];
	assign spi_miso_oe_out = ~spi_cs_n_in;

	// Frame completion marked at chip select release, only at exactly 16 bits [R22]
	always_ff @(posedge spi_cs_n_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			lk_tog_r   <= 1'b0;
			lk_frame_r <= 16'h0000;
		end else if (lk_cnt_r == 5'(FRAME_BITS)) begin
			lk_tog_r   <= ~lk_tog_r;
			lk_frame_r <= lk_shift_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register read decode, used only by the link transmit path
	logic [7:0] mode_sup_r;
	logic [7:0] hardware_ctrl_r;

	function automatic logic [7:0] rd_mux(input logic [6:0] a);
		unique case (a)
			ADDR_MODE_SUP: rd_mux = mode_sup_r & MODE_SUP_MASK; // [R05]
			ADDR_HARDWARE_CTRL:  rd_mux = hardware_ctrl_r & HARDWARE_CTRL_MASK; // [R05]
			default:       rd_mux = 8'h00;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Core domain: toggle synchroniser, frame data stable when toggle seen
	logic [2:0] tog_sync_r;
	logic       frame_evt;
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			tog_sync_r <= 3'b000;
		else
			tog_sync_r <= {tog_sync_r[1:0], lk_tog_r};
	end
	assign frame_evt = tog_sync_r[2] ^ tog_sync_r[1];

	logic [1:0] ext_sync1_r;
	logic [1:0] ext_sync2_r;
	logic       fail_sync1_r;
	logic       fail_sync2_r;
	logic       restart_d_r;
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			ext_sync1_r  <= 2'b00;
			ext_sync2_r  <= 2'b00;
			fail_sync1_r <= 1'b0;
			fail_sync2_r <= 1'b0;
			restart_d_r  <= 1'b0;
		end else begin
			ext_sync1_r  <= {overtemp_in, restart_in};
			ext_sync2_r  <= ext_sync1_r;
			fail_sync1_r <= failure_flag_in;
			fail_sync2_r <= fail_sync1_r;
			restart_d_r  <= ext_sync2_r[0];
		end
	end

	logic restart_evt;
	logic overtemp;
	assign restart_evt = ext_sync2_r[0] & ~restart_d_r;
	assign overtemp    = ext_sync2_r[1];

	logic [6:0] wr_addr;
	logic [7:0] wr_data;
	logic       wr_en;
	assign wr_addr = lk_frame_r[6:0]; // [R01]
	assign wr_data = lk_frame_r[15:8]; // [R02]
	assign wr_en   = frame_evt & lk_frame_r[ACCESS_BIT]; // [R03] [R04]

	// Write strobe for one register; shared by soft reset and both registers
	function automatic logic wr_hit(input logic [6:0] a);
		wr_hit = wr_en && (wr_addr == a);
	endfunction

	logic soft_rst;
	assign soft_rst = wr_hit(ADDR_MODE_SUP)
		&& wr_data[MODE_LSB +: 2] == SMS_MODE_SRST; // [R09]

	////////////////////////////////////////////////////////////////////////////
	// Mode and supply control register
	logic [1:0] cur_mode;
	logic [1:0] req_mode;
	assign cur_mode = mode_sup_r[MODE_LSB +: 2];
	assign req_mode = wr_data[MODE_LSB +: 2];

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			mode_sup_r <= MODE_SUP_RST;
		end else if (soft_rst) begin
			mode_sup_r <= MODE_SUP_RST; // [R08]
		end else if (restart_evt) begin
			// Normal mode, supply off, threshold kept [R08] [R11] [R12]
			mode_sup_r <= (mode_sup_r & MODE_SUP_KEEP) | MODE_SUP_RST;
		end else begin
			if (wr_hit(ADDR_MODE_SUP)) begin
				mode_sup_r <= wr_data & MODE_SUP_MASK; // [R04] [R06]
				if (cur_mode == SMS_MODE_STOP && req_mode == SMS_MODE_SLEEP)
					mode_sup_r[MODE_LSB +: 2] <= cur_mode; // [R10]
			end
			if (overtemp)
				mode_sup_r[SUPPLY_LSB +: 2] <= 2'b00; // [R12]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Hardware control register
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			hardware_ctrl_r <= HARDWARE_CTRL_RST;
		else if (soft_rst)
			hardware_ctrl_r <= HARDWARE_CTRL_RST; // [R08]
		else if (restart_evt)
			hardware_ctrl_r <= (hardware_ctrl_r & HARDWARE_CTRL_KEEP) | HARDWARE_CTRL_RST; // [R08] [R20]
		else if (wr_hit(ADDR_HARDWARE_CTRL))
			hardware_ctrl_r <= wr_data & HARDWARE_CTRL_MASK; // [R06] [R07]
	end

	////////////////////////////////////////////////////////////////////////////
	// Soft reset pulse on the reset output pin
	logic [7:0] srst_cnt_r;
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			srst_cnt_r <= 8'h00;
		else if (soft_rst && !hardware_ctrl_r[SOFT_RST_SEL_BIT])
			srst_cnt_r <= 8'(SOFT_RST_CYC); // [R17]
		else if (srst_cnt_r != 8'h00)
			srst_cnt_r <= srst_cnt_r - 8'h01;
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			reset_output_pin_n_out  <= 1'b0;
			failure_output_pins_out <= 1'b0;
		end else begin
			reset_output_pin_n_out  <= (srst_cnt_r == 8'h00); // [R17]
			// Flag-driven activation survives clearing of the force bit [R18] [R21]
			failure_output_pins_out <= hardware_ctrl_r[FO_FORCE_BIT] | fail_sync2_r;
		end
	end

	assign mode_out                             = cur_mode; // [R09]
	assign second_supply_enable_out             = mode_sup_r[SUPPLY_LSB +: 2]; // [R13]
	assign main_supply_overvoltage_reaction_out = mode_sup_r[OV_REACT_BIT]; // [R14]
	assign main_supply_reset_threshold_out      = mode_sup_r[1:0]; // [R15]
	assign wd_first_failure_out                 = hardware_ctrl_r[WD_CFG_BIT]; // [R19]
endmodule
`default_nettype wire

//--- hdl/sms_pkg.sv
// Constants for the serial mode and supply control register bank
// Contract
// [R01] Frame is 16 bits: 7-bit address, access bit, then data byte.
// [R02] Data bits D0..D7 travel at frame bit positions 8..15.
// [R03] Frame bit 7 low reads the register and leaves it unchanged.
// [R04] Frame bit 7 high writes the data byte to the register.
// [R05] Reserved bits always read as zero.
// [R06] Host writes zero to every reserved bit.
// [R07] Control bits change only by host write, except hardware-modifiable bits.
// [R08] Power-on or soft reset loads reset values; restart loads restart values.
// [R09] Mode field 7:6: normal, sleep, stop; 11 executes soft reset.
// [R10] Serial request from stop to sleep is refused.
// [R11] Entering restart sets mode to normal.
// [R12] Restart or overtemperature forces secondary supply enable off.
// [R13] Secondary supply field 4:3 encodes off, normal, normal+stop, always.
// [R14] Bit 2 high lets main-supply overvoltage trigger restart or fail-safe.
// [R15] Bits 1:0 choose one of four main-supply reset thresholds.
// [R16] During a write, serial output returns the previous register content.
// [R17] Hardware control bit 6 low pulls reset output low on soft reset.
// [R18] Hardware control bit 5 forces failure outputs on by software.
// [R19] Hardware control bit 0 picks first or second watchdog failure.
// [R20] Restart clears software failure force and disables failure outputs; here the outputs stay on while the failure flag is high.
// [R21] Clearing force leaves failure-triggered outputs on until failure flag clears.
// [R22] Only complete 16-bit frames under chip select take effect.
package sms_pkg;
	localparam int          FRAME_BITS      = 16;
	localparam int          ACCESS_BIT      = 7;
	localparam logic [6:0]  ADDR_MODE_SUP   = 7'h01;
	localparam logic [6:0]  ADDR_HARDWARE_CTRL    = 7'h02;
	localparam logic [7:0]  MODE_SUP_RST    = 8'h00;
	localparam logic [7:0]  HARDWARE_CTRL_RST     = 8'h00;
	localparam logic [7:0]  MODE_SUP_MASK   = 8'hdf;
	localparam logic [7:0]  HARDWARE_CTRL_MASK    = 8'h61;
	localparam logic [7:0]  MODE_SUP_KEEP   = 8'h03;
	localparam logic [7:0]  HARDWARE_CTRL_KEEP    = 8'h41;
	localparam int          MODE_LSB        = 6;
	localparam int          SUPPLY_LSB      = 3;
	localparam int          OV_REACT_BIT    = 2;
	localparam int          SOFT_RST_SEL_BIT = 6;
	localparam int          FO_FORCE_BIT    = 5;
	localparam int          WD_CFG_BIT      = 0;
	localparam int          SOFT_RST_NS     = 100;
	localparam int          CLK_MHZ         = 200;
	localparam int          SOFT_RST_CYC    = (SOFT_RST_NS * CLK_MHZ + 999) / 1000;

	typedef enum logic [1:0] {
		SMS_MODE_NORMAL = 2'b00,
		SMS_MODE_SLEEP  = 2'b01,
		SMS_MODE_STOP   = 2'b10,
		SMS_MODE_SRST   = 2'b11
	} sms_mode_t;
endpackage

//--- testbench/sms_spi_host.sv
// Host model that sends serial command frames
`timescale 1ns/1ps
`default_nettype none
module sms_spi_host (
	output logic		spi_clk_out,
	output logic		spi_cs_n_out,
	output logic		spi_mosi_out,
	input  wire logic	spi_miso_in
);
	logic	[7:0]	rd;
	event		got;
	initial begin
		spi_clk_out = 1'b0;
		spi_cs_n_out = 1'b1;
		spi_mosi_out = 1'b0;
	end
	// Clock runs only inside frames; a released data line shows its inverse
	task automatic frame(input logic [15:0] f, input int n);
		spi_cs_n_out = 1'b0;
		#15;
		for (int i = 0; i < n; i++) begin
			spi_mosi_out = f[i];
			#15;
			spi_clk_out = 1'b1;
			if (i > 7) rd[i-8] = spi_miso_in;
			#15;
			spi_clk_out = 1'b0;
		end
		#15;
		spi_cs_n_out = 1'b1;
		spi_mosi_out = ~spi_mosi_out;
		if (n == 16) ->got;
		#40;
	endtask
endmodule
`default_nettype wire

//--- testbench/sms_spi_mode_supply_ctrl_checker.sv
// Port assertions for the mode and supply register bank
`timescale 1ns/1ps
`default_nettype none
module sms_spi_mode_supply_ctrl_checker
	import sms_pkg::*;
(
	input wire logic	clk_in,
	input wire logic	sys_rst_in,
	input wire logic	spi_cs_n_in,
	input wire logic	restart_in,
	input wire logic	overtemp_in,
	input wire logic	failure_flag_in,
	input wire logic [1:0]	mode_out,
	input wire logic [1:0]	second_supply_enable_out,
	input wire logic [1:0]	main_supply_reset_threshold_out,
	input wire logic	wd_first_failure_out,
	input wire logic	reset_output_pin_n_out,
	input wire logic	failure_output_pins_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	////////////////////////////////////////////////////////////////////////////////
	a_no_stop_sleep: assert property (($past(mode_out) == SMS_MODE_STOP) |->
		(mode_out != SMS_MODE_SLEEP)) else $error("stop went to sleep");
	a_restart_normal: assert property ($rose(restart_in) |->
		##[1:8] (mode_out == SMS_MODE_NORMAL)) else $error("restart kept mode");
	a_restart_supply_off: assert property ($rose(restart_in) |->
		##[1:8] (second_supply_enable_out == 2'b00)) else $error("restart kept supply");
	a_heat_supply_off: assert property (overtemp_in [*6] |->
		(second_supply_enable_out == 2'b00)) else $error("supply on while hot");
	a_flag_drives_fo: assert property (failure_flag_in [*5] |->
		failure_output_pins_out) else $error("failure output off with flag");
	a_restart_drops_fo: assert property ($rose(restart_in) ##1 (!failure_flag_in) [*8] |->
		!failure_output_pins_out) else $error("failure output on after restart");
	a_frame_quiet: assert property ((!spi_cs_n_in && !restart_in && !overtemp_in) [*8] |->
		$stable(main_supply_reset_threshold_out) && $stable(wd_first_failure_out))
		else $error("config changed inside frame");
	a_soft_rst_pulse: assert property ($fell(reset_output_pin_n_out) |->
		!reset_output_pin_n_out [*8]) else $error("reset pulse too short");
endmodule
bind sms_spi_mode_supply_ctrl sms_spi_mode_supply_ctrl_checker u_checker (.clk_in, .sys_rst_in,
	.spi_cs_n_in, .restart_in, .overtemp_in, .failure_flag_in, .mode_out,
	.second_supply_enable_out, .main_supply_reset_threshold_out, .wd_first_failure_out,
	.reset_output_pin_n_out, .failure_output_pins_out);
`default_nettype wire

//--- testbench/sms_spi_mode_supply_ctrl_bench.sv
// Self-checking bench for the mode and supply register bank
`timescale 1ns/1ps
`default_nettype none
module sms_spi_mode_supply_ctrl_bench;
	logic	clk_in, sys_rst_in, spi_clk_in, spi_cs_n_in, spi_mosi_in, spi_miso_out;
	logic	spi_miso_oe_out, restart_in, overtemp_in, failure_flag_in;
	logic	main_supply_overvoltage_reaction_out, wd_first_failure_out;
	logic	reset_output_pin_n_out, failure_output_pins_out;
	logic	[1:0]	mode_out, second_supply_enable_out, main_supply_reset_threshold_out;
	logic	[7:0]	q[$];
	logic	[7:0]	v;
	int	err_count, n_checks;
	sms_spi_mode_supply_ctrl u_sms_spi_mode_supply_ctrl (.clk_in, .sys_rst_in, .spi_clk_in,
		.spi_cs_n_in, .spi_mosi_in, .spi_miso_out, .spi_miso_oe_out, .restart_in, .overtemp_in,
		.failure_flag_in, .mode_out, .second_supply_enable_out, .main_supply_reset_threshold_out,
		.main_supply_overvoltage_reaction_out, .wd_first_failure_out, .reset_output_pin_n_out,
		.failure_output_pins_out);
	sms_spi_host u_host (.spi_clk_out(spi_clk_in), .spi_cs_n_out(spi_cs_n_in),
		.spi_mosi_out(spi_mosi_in), .spi_miso_in(spi_miso_out));
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic check(input string nm, input logic [7:0] s, input logic [7:0] e);
		n_checks++;
		if (s !== e) begin
			err_count++;
			$display("unexpected %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic xf(input logic [6:0] a, input logic w, input logic [7:0] d, input logic [7:0] e);
		q.push_back(e);
		u_host.frame({d, w, a}, 16);
	endtask
	task automatic wt(input string s);
		repeat (10) @(posedge clk_in);
		$display("end %s", s);
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	always @(u_host.got) check("read", u_host.rd, q.pop_front());
	initial begin
		#100000;
		err_count++;
		conclude();
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{sys_rst_in, restart_in, overtemp_in, failure_flag_in} = 4'h8;
		repeat (5) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		wt("reset");
		xf(7'h01, 1'b0, 8'hff, 8'h00);
		xf(7'h02, 1'b0, 8'h00, 8'h00);
		xf(7'h01, 1'b0, 8'h00, 8'h00);
		v = lfsr(8'h54) & 8'h1f;
		xf(7'h01, 1'b1, v, 8'h00);
		u_host.frame({8'hff, 1'b1, 7'h01}, 15);
		xf(7'h01, 1'b0, 8'h00, v);
		check("supply", {6'h00, second_supply_enable_out}, {6'h00, v[4:3]});
		check("react", {7'h00, main_supply_overvoltage_reaction_out}, {7'h00, v[2]});
		check("thresh", {6'h00, main_supply_reset_threshold_out}, {6'h00, v[1:0]});
		check("oe", {7'h00, spi_miso_oe_out}, 8'h00);
		xf(7'h01, 1'b1, 8'h80 | v, v);
		xf(7'h01, 1'b1, 8'h40 | v, 8'h80 | v);
		xf(7'h01, 1'b0, 8'h00, 8'h80 | v);
		xf(7'h02, 1'b1, 8'h61, 8'h00);
		xf(7'h05, 1'b1, 8'h5a, 8'h00);
		xf(7'h05, 1'b0, 8'h00, 8'h00);
		check("force", {7'h00, failure_output_pins_out}, 8'h01);
		check("wd", {7'h00, wd_first_failure_out}, 8'h01);
		wt("write");
		restart_in <= 1'b1;
		wt("restart");
		restart_in <= 1'b0;
		check("mode", {6'h00, mode_out}, 8'h00);
		check("fo", {7'h00, failure_output_pins_out}, 8'h00);
		xf(7'h02, 1'b0, 8'h00, 8'h41);
		xf(7'h01, 1'b0, 8'h00, v & 8'h03);
		@(posedge clk_in);
		failure_flag_in <= 1'b1;
		overtemp_in <= 1'b1;
		wt("flag");
		check("fo", {7'h00, failure_output_pins_out}, 8'h01);
		xf(7'h01, 1'b1, 8'h1b, v & 8'h03);
		xf(7'h01, 1'b0, 8'h00, 8'h03);
		@(posedge clk_in);
		overtemp_in <= 1'b0;
		failure_flag_in <= 1'b0;
		xf(7'h02, 1'b1, 8'h00, 8'h41);
		xf(7'h01, 1'b1, 8'hc0, 8'h03);
		check("ro", {7'h00, reset_output_pin_n_out}, 8'h00);
		wt("soft reset");
		xf(7'h01, 1'b0, 8'h00, 8'h00);
		check("ro", {7'h00, reset_output_pin_n_out}, 8'h01);
		xf(7'h01, 1'b1, 8'h40, 8'h00);
		check("sleep", {6'h00, mode_out}, 8'h01);
		wt("sleep");
		conclude();
	end
endmodule
`default_nettype wire
